// file: twcp_params.svh
// constants for the two-wire configuration write port
// assumes inclusion by the package, the write port and the testbench
`ifndef TWCP_PARAMS_SVH
`define TWCP_PARAMS_SVH
`define TWCP_ADDR_W       3
`define TWCP_DATA_W       8
`define TWCP_SHIFT_W      11
`define TWCP_BIT_CNT_W    4
`define TWCP_FRAME_BITS   4'hb
`define TWCP_ADDR_BW      3'h4
`define TWCP_ADDR_AT      3'h5
`define TWCP_BW_MSB       7
`define TWCP_BW_LSB       4
`define TWCP_AMP_MSB      7
`define TWCP_AMP_LSB      6
`define TWCP_RES_MSB      5
`define TWCP_RES_LSB      0
`define TWCP_REG_RESET    8'h00
`define TWCP_ADDR_LSB     8
`endif

// file: twcp_pkg.sv
// types shared by the two-wire configuration write port
// assumes twcp_params.svh is on the include path
`include "twcp_params.svh"
package twcp_pkg;
  typedef struct packed {
    logic [3:0] bandwidth_code;
    logic [1:0] amplitude_code;
    logic [5:0] threshold_res_code;
  } twcp_cfg_type;
  typedef struct packed {
    logic sck;
    logic sda;
  } twcp_line_type;
  typedef enum logic [1:0] {
    TWCP_IDLE  = 2'b00,
    TWCP_SHIFT = 2'b01
  } twcp_state_type;
endpackage

// file: twcp_line_sync.sv
// two-stage synchroniser and edge finder for the serial clock and data
// assumes asynchronous pin inputs and one system clock
`timescale 1ns/1ps
`default_nettype none
module twcp_line_sync
  import twcp_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // pins
  input  wire twcp_line_type line_in,
  // synchronised levels and edges
  output var  twcp_line_type line_sync,
  output var  logic          sck_rise,
  output var  logic          sda_fall,
  output var  logic          sda_rise
);
  twcp_line_type meta_ff;
  twcp_line_type sync_ff;
  twcp_line_type last_ff;
  twcp_line_type nxt_meta;
  twcp_line_type nxt_sync;
  twcp_line_type nxt_last;

  always_comb
  begin
    nxt_meta = line_in;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 2'b11;
      sync_ff <= 2'b11;
      last_ff <= 2'b11;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  assign line_sync = sync_ff;
  assign sck_rise  = sync_ff.sck & ~last_ff.sck;
  assign sda_fall  = ~sync_ff.sda & last_ff.sda & sync_ff.sck & last_ff.sck;
  assign sda_rise  = sync_ff.sda & ~last_ff.sda & sync_ff.sck & last_ff.sck;
endmodule
`default_nettype wire

// file: twcp_write_port.sv
// write-only two-wire configuration port with its two registers
// assumes sck and sda come from an outside open-drain master, asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "twcp_params.svh"
module twcp_write_port
  import twcp_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // serial pins
  input  wire logic         sck,
  input  wire logic         sda,
  output var  logic         sda_out,
  output var  logic         sda_oe,
  // configuration outputs
  output var  twcp_cfg_type cfg,
  output var  logic [5:0]   res_shunt_en,
  output var  logic         frame_active
);
  twcp_line_type                line_sync;
  logic                         sck_rise;
  logic                         sda_fall;
  logic                         sda_rise;
  twcp_state_type               state_ff;
  twcp_state_type               nxt_state;
  logic [`TWCP_SHIFT_W-1:0]     shift_ff;
  logic [`TWCP_SHIFT_W-1:0]     nxt_shift;
  logic [`TWCP_BIT_CNT_W-1:0]   cnt_ff;
  logic [`TWCP_BIT_CNT_W-1:0]   nxt_cnt;
  logic                         rose_ff;
  logic                         nxt_rose;
  logic [`TWCP_DATA_W-1:0]      bw_reg_ff;
  logic [`TWCP_DATA_W-1:0]      at_reg_ff;
  logic [`TWCP_DATA_W-1:0]      nxt_bw_reg;
  logic [`TWCP_DATA_W-1:0]      nxt_at_reg;
  logic [7:0]                   sel;
  logic                         stop_ok;
  logic [`TWCP_ADDR_W-1:0]      addr;
  logic [`TWCP_DATA_W-1:0]      data;

  twcp_line_sync u_sync
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .line_in   ({sck, sda}),
    .line_sync (line_sync),
    .sck_rise  (sck_rise),
    .sda_fall  (sda_fall),
    .sda_rise  (sda_rise)
  );

  assign addr = shift_ff[`TWCP_SHIFT_W-1:`TWCP_ADDR_LSB];
  assign data = shift_ff[`TWCP_DATA_W-1:0];

  generate
    for (genvar i = 0; i < 8; i++)
    begin : g_dec
      assign sel[i] = (addr == `TWCP_ADDR_W'(i));
    end
  endgenerate

  // stop only after a full eleven-bit frame and a clock rise
  assign stop_ok = (state_ff == TWCP_SHIFT) && sda_rise && rose_ff &&
                   (cnt_ff == `TWCP_FRAME_BITS);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_cnt   = cnt_ff;
    nxt_rose  = rose_ff;
    // a start, even mid-frame, restarts and drops the partial frame
    if (sda_fall)
    begin
      nxt_state = TWCP_SHIFT;
      nxt_cnt   = '0;
      nxt_rose  = 1'b0;
    end
    else if (state_ff == TWCP_SHIFT)
    begin
      if (sda_rise)
      begin
        nxt_state = TWCP_IDLE;
      end
      // shift in msb first while clock goes high
      else if (sck_rise)
      begin
        nxt_rose = 1'b1;
        if (cnt_ff != `TWCP_FRAME_BITS)
        begin
          nxt_shift = {shift_ff[`TWCP_SHIFT_W-2:0], line_sync.sda};
          nxt_cnt   = cnt_ff + `TWCP_BIT_CNT_W'(1);
        end
      end
    end
  end

  always_comb
  begin
    nxt_bw_reg = bw_reg_ff;
    nxt_at_reg = at_reg_ff;
    // parallel copy only to implemented addresses
    if (stop_ok && sel[`TWCP_ADDR_BW])
    begin
      nxt_bw_reg = data;
    end
    if (stop_ok && sel[`TWCP_ADDR_AT])
    begin
      nxt_at_reg = data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff  <= TWCP_IDLE;
      shift_ff  <= '0;
      cnt_ff    <= '0;
      rose_ff   <= 1'b0;
      bw_reg_ff <= `TWCP_REG_RESET;
      at_reg_ff <= `TWCP_REG_RESET;
      cfg       <= '0;
      res_shunt_en <= '0;
      frame_active <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      shift_ff  <= nxt_shift;
      cnt_ff    <= nxt_cnt;
      rose_ff   <= nxt_rose;
      bw_reg_ff <= nxt_bw_reg;
      at_reg_ff <= nxt_at_reg;
      cfg.bandwidth_code     <= nxt_bw_reg[`TWCP_BW_MSB:`TWCP_BW_LSB];
      cfg.amplitude_code     <= nxt_at_reg[`TWCP_AMP_MSB:`TWCP_AMP_LSB];
      cfg.threshold_res_code <= nxt_at_reg[`TWCP_RES_MSB:`TWCP_RES_LSB];
      // a set bit shunts its binary-weighted segment
      res_shunt_en <= nxt_at_reg[`TWCP_RES_MSB:`TWCP_RES_LSB];
      frame_active <= (nxt_state == TWCP_SHIFT);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end
  end

  a_bw_update: assert property (@(posedge clk) disable iff (!rst_n)
    (stop_ok && sel[`TWCP_ADDR_BW]) |=> (bw_reg_ff == $past(data)))
    else $error("bandwidth register not loaded on stop");
  a_at_update: assert property (@(posedge clk) disable iff (!rst_n)
    (stop_ok && sel[`TWCP_ADDR_AT]) |=> (at_reg_ff == $past(data)))
    else $error("amplitude register not loaded on stop");
  a_bad_addr: assert property (@(posedge clk) disable iff (!rst_n)
    (!(stop_ok && (sel[`TWCP_ADDR_BW] || sel[`TWCP_ADDR_AT]))) |=>
    $stable(bw_reg_ff) && $stable(at_reg_ff))
    else $error("register changed without valid stop");
  a_start_clear: assert property (@(posedge clk) disable iff (!rst_n)
    sda_fall |=> (state_ff == TWCP_SHIFT) && (cnt_ff == '0))
    else $error("start did not open a frame");
  a_cnt_limit: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_ff <= `TWCP_FRAME_BITS)
    else $error("bit count beyond frame");
  a_bw_field: assert property (@(posedge clk) disable iff (!rst_n)
    (stop_ok && sel[`TWCP_ADDR_BW]) |=>
    (cfg.bandwidth_code == $past(data[`TWCP_BW_MSB:`TWCP_BW_LSB])))
    else $error("bandwidth field mismatch");
  a_amp_field: assert property (@(posedge clk) disable iff (!rst_n)
    (stop_ok && sel[`TWCP_ADDR_AT]) |=>
    (cfg.amplitude_code == $past(data[`TWCP_AMP_MSB:`TWCP_AMP_LSB])) &&
    (cfg.threshold_res_code == $past(data[`TWCP_RES_MSB:`TWCP_RES_LSB])))
    else $error("amplitude or threshold field mismatch");
  a_sel_onehot: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(sel))
    else $error("address decode not one-hot");
  a_restart_drop: assert property (@(posedge clk) disable iff (!rst_n)
    sda_fall |=> $stable(bw_reg_ff) && $stable(at_reg_ff))
    else $error("restart changed a register");
  a_short_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (sda_rise && (cnt_ff != `TWCP_FRAME_BITS)) |=> $stable(bw_reg_ff) && $stable(at_reg_ff))
    else $error("short frame changed a register");
  a_stop_idle: assert property (@(posedge clk) disable iff (!rst_n)
    stop_ok |=> (state_ff == TWCP_IDLE) && !frame_active)
    else $error("stop did not end frame");
  a_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
    !sda_oe)
    else $error("data line driven");
  a_shunt_map: assert property (@(posedge clk) disable iff (!rst_n)
    res_shunt_en == cfg.threshold_res_code)
    else $error("shunt enables differ from code");

  c_bw_write: cover property (@(posedge clk) stop_ok && sel[`TWCP_ADDR_BW]);
  c_at_write: cover property (@(posedge clk) stop_ok && sel[`TWCP_ADDR_AT]);
  c_restart: cover property (@(posedge clk) sda_fall && state_ff == TWCP_SHIFT);
  c_short_stop: cover property (@(posedge clk) sda_rise && state_ff == TWCP_SHIFT && !stop_ok);
endmodule
`default_nettype wire

// file: twcp_master_model.sv
// master model driving the serial clock and data pins
// assumes clk paces every pin change; released pins read high
`timescale 1ns/1ps
`default_nettype none
module twcp_master_model
(
  // pacing clock
  input  wire logic clk,
  // serial pins
  output var  logic sck,
  output var  logic sda
);
  initial
  begin
    sck = 1'b1;
    sda = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start();
    if (!(sck && sda))
    begin
      sck <= 1'b0;
      wait_clk(2);
      sda <= 1'b1;
      wait_clk(2);
      sck <= 1'b1;
      wait_clk(4);
    end
    sda <= 1'b0;
    wait_clk(4);
  endtask
  // bits msb first, data changed while clock low
  task automatic send_bits(input logic [10:0] bits, input int n);
    for (int i = 10; i > 10 - n; i--)
    begin
      sck <= 1'b0;
      wait_clk(2);
      sda <= bits[i];
      wait_clk(2);
      sck <= 1'b1;
      wait_clk(4);
    end
  endtask
  task automatic stop();
    sck <= 1'b0;
    wait_clk(2);
    sda <= 1'b0;
    wait_clk(2);
    sck <= 1'b1;
    wait_clk(4);
    sda <= 1'b1;
    wait_clk(4);
  endtask
  task automatic frame(input logic [2:0] addr, input logic [7:0] data, input int n,
                       input logic do_stop);
    start();
    send_bits({addr, data}, n);
    if (do_stop)
      stop();
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the two-wire configuration write port
// assumes the master model paces frames at a 160 ns serial clock
`timescale 1ns/1ps
`default_nettype none
`include "twcp_params.svh"
module testbench;
  import twcp_pkg::*;
  logic         clk;
  logic         rst_n;
  logic         sck;
  logic         sda;
  logic         sda_out;
  logic         sda_oe;
  logic [5:0]   res_shunt_en;
  logic         frame_active;
  twcp_cfg_type cfg;
  twcp_cfg_type exp_cfg;
  int           fail_count = 0;
  int           checked = 0;
  initial clk = 1'b0;
  always #10 clk = ~clk;
  twcp_master_model m (.clk(clk), .sck(sck), .sda(sda));
  twcp_write_port dut
  (
    .clk          (clk),
    .rst_n        (rst_n),
    .sck          (sck),
    .sda          (sda),
    .sda_out      (sda_out),
    .sda_oe       (sda_oe),
    .cfg          (cfg),
    .res_shunt_en (res_shunt_en),
    .frame_active (frame_active)
  );
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // full write frame, then compare every output
  task automatic wr(input logic [2:0] addr, input logic [7:0] data);
    m.frame(addr, data, 11, 1'b1);
    if (addr == `TWCP_ADDR_BW)
      exp_cfg.bandwidth_code = data[7:4];
    if (addr == `TWCP_ADDR_AT)
      exp_cfg = {exp_cfg.bandwidth_code, data};
    check(cfg, exp_cfg);
    check(res_shunt_en, exp_cfg.threshold_res_code);
    check({sda_oe, sda_out}, 2'b00);
    check(frame_active, 1'b0);
  endtask
  initial
  begin
    #1000000;
    fail_count++;
    close_out();
  end
  initial
  begin
    rst_n = 1'b0;
    exp_cfg = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    m.start();
    check(frame_active, 1'b1);
    // a full frame left without a stop, then cut by a new start
    m.send_bits({3'h4, 8'hff}, 11);
    check(frame_active, 1'b1);
    wr(3'h5, 8'h6d);
    for (int i = 0; i < 16; i++)
      wr(3'h4, {i[3:0], 4'h5});
    for (int i = 0; i < 4; i++)
      wr(3'h5, {i[1:0], 6'(i * 21)});
    for (int a = 0; a < 8; a++)
      if (a != 4 && a != 5)
        wr(a[2:0], 8'hff);
    // nine bits plus the clock rise of the stop leave the frame one bit short
    m.frame(3'h4, 8'h00, 9, 1'b1);
    check(cfg, exp_cfg);
    check(frame_active, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
